//--- rtl/ulpc_pkg.sv
/*
 * ulpc_pkg: offsets, field positions, reset values and timing constants
 * of the link power / timeout configuration word.
 * assumes: a single 20 MHz controller clock.
 */
package ulpc_pkg;
  localparam logic [11:0] ULPC_CFG_OFF = 12'h084;
  localparam logic [11:0] ULPC_STAT_OFF = 12'h088;
  localparam int ULPC_U1_LSB = 24;
  localparam int ULPC_U2TO_LSB = 16;
  localparam int ULPC_HSCAL_LSB = 13;
  localparam int ULPC_U2SELF_BIT = 12;
  localparam int ULPC_U2HOST_BIT = 11;
  localparam logic [7:0] ULPC_U1_NOIMG = 8'h00;
  localparam logic [7:0] ULPC_U2TO_RST = 8'h00;
  localparam logic [2:0] ULPC_HSCAL_RST = 3'h0;
  localparam logic ULPC_U2SELF_RST = 1'b0;
  localparam logic ULPC_U2HOST_RST = 1'b0;
  localparam int ULPC_CLK_HZ = 20_000_000;
  localparam int ULPC_TICK_US = 1;
  localparam int ULPC_TICK_CYC = ULPC_CLK_HZ / 1_000_000 * ULPC_TICK_US;
  localparam logic [9:0] ULPC_HS_BASE_BITS = 10'h0300;
  localparam logic [9:0] ULPC_HS_MIN_BITS = 10'h02E0;
  localparam logic [9:0] ULPC_HS_MAX_BITS = 10'h0330;
  localparam logic [4:0] ULPC_HS_BITS_PER_CLK = 5'h08;
  typedef enum logic [2:0] {
    ULPC_IDLE = 3'b001,
    ULPC_WAIT = 3'b010,
    ULPC_REQ  = 3'b100
  } ulpc_u1_state_t;
endpackage

//--- rtl/ulpc_top.sv
/*
 * ulpc_top: link power and high-speed timeout configuration word with
 * u1 entry wait timer, u2 enables and port-supplied u2_idle_timeout_from_port capture.
 * assumes: register port strobes synchronous to clk_i; link layer gives
 * one-cycle pulses for lmp receipt and usb/lite resets; 60 MHz phy clock.
 */
`timescale 1ns/10ps
module ulpc_top
  import ulpc_pkg::*;
#(
  parameter int TICK_CYC = ulpc_pkg::ULPC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic usb_reset_i,
  input wire logic lite_reset_i,
  input wire logic soft_reset_shield_i,
  input wire logic image_valid_i,
  input wire logic [7:0] image_u1_idle_wait_us_i,
  input wire logic host_u1_enable_i,
  input wire logic host_u2_enable_i,
  input wire logic u2_lmp_valid_i,
  input wire logic [7:0] u2_lmp_timeout_i,
  input wire logic link_idle_i,
  input wire logic host_u2_request_i,
  output logic u1_entry_request_o,
  output logic u2_self_entry_ok_o,
  output logic u2_host_accept_o,
  output logic [9:0] hs_timeout_bits_o
);
  import ulpc_pkg::*;

  logic [7:0] u1_wait_q;
  logic [7:0] u2_idle_timeout_from_port_q;
  logic [2:0] hs_cal_q;
  logic u2_self_q;
  logic u2_host_q;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [7:0] us_cnt_q;
  logic u1_en_q;
  ulpc_u1_state_t st_q;
  ulpc_u1_state_t st_d;

  wire link_rst = usb_reset_i | lite_reset_i;
  wire sel_cfg = (addr_i == ULPC_CFG_OFF);
  wire sel_stat = (addr_i == ULPC_STAT_OFF);
  wire cfg_wr = wr_i & sel_cfg;
  wire u1_rise = host_u1_enable_i & ~u1_en_q;
  wire [7:0] u1_reload = image_valid_i ? image_u1_idle_wait_us_i : ULPC_U1_NOIMG;
  wire [31:0] cfg_word = {u1_wait_q, u2_idle_timeout_from_port_q, hs_cal_q, u2_self_q, u2_host_q, 11'h000};
  wire u2_self_ok_w = u2_self_q & host_u2_enable_i;
  wire [31:0] stat_word = {28'h000_0000, st_q, u2_self_ok_w};
  wire tick_wrap = (tick_cnt_q == 16'(TICK_CYC - 1));
  wire wait_done = (us_cnt_q >= u1_wait_q);
  // only the 60 mhz factor exists; the 30 mhz doubling is not built
  wire [9:0] hs_add = 10'(hs_cal_q) * 10'(ULPC_HS_BITS_PER_CLK);

  // config fields: link resets reload u1 wait; u2 enables keep value if shielded
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      u1_wait_q <= ULPC_U1_NOIMG;
      hs_cal_q <= ULPC_HSCAL_RST;
      u2_self_q <= ULPC_U2SELF_RST;
      u2_host_q <= ULPC_U2HOST_RST;
    end else if (link_rst) begin
      u1_wait_q <= u1_reload;
      if (!soft_reset_shield_i) begin
        u2_self_q <= ULPC_U2SELF_RST;
        u2_host_q <= ULPC_U2HOST_RST;
      end
    end else if (cfg_wr) begin
      u1_wait_q <= wdata_i[ULPC_U1_LSB +: 8];
      hs_cal_q <= wdata_i[ULPC_HSCAL_LSB +: 3];
      u2_self_q <= wdata_i[ULPC_U2SELF_BIT];
      u2_host_q <= wdata_i[ULPC_U2HOST_BIT];
    end
  end

  // port-supplied u2_idle_timeout_from_port, read only; software writes do not touch it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      u2_idle_timeout_from_port_q <= ULPC_U2TO_RST;
    end else if (u2_lmp_valid_i) begin
      u2_idle_timeout_from_port_q <= u2_lmp_timeout_i;
    end
  end

  // one microsecond tick from the controller clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i || u1_rise) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q <= tick_wrap;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ULPC_IDLE: if (u1_rise) st_d = ULPC_WAIT;
      ULPC_WAIT: begin
        if (!host_u1_enable_i || !link_idle_i) st_d = ULPC_IDLE;
        else if (wait_done) st_d = ULPC_REQ;
      end
      ULPC_REQ: st_d = ULPC_IDLE;
      default: st_d = ULPC_IDLE;
    endcase
  end

  // u1 wait counter; a fresh enable edge restarts it even mid-wait
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q <= ULPC_IDLE;
      us_cnt_q <= 8'h00;
      u1_en_q <= 1'b0;
    end else begin
      st_q <= u1_rise ? ULPC_WAIT : st_d;
      u1_en_q <= host_u1_enable_i;
      if (u1_rise || st_q != ULPC_WAIT) us_cnt_q <= 8'h00;
      else if (tick_q && !wait_done) us_cnt_q <= us_cnt_q + 8'h01;
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      u1_entry_request_o <= 1'b0;
      u2_self_entry_ok_o <= 1'b0;
      u2_host_accept_o <= 1'b0;
      hs_timeout_bits_o <= ULPC_HS_BASE_BITS;
      rdata_o <= 32'h0000_0000;
    end else begin
      u1_entry_request_o <= (st_d == ULPC_REQ) && !u1_rise;
      u2_self_entry_ok_o <= u2_self_ok_w;
      u2_host_accept_o <= u2_host_q & host_u2_request_i;
      hs_timeout_bits_o <= ULPC_HS_BASE_BITS + hs_add;
      if (rd_i && sel_cfg) rdata_o <= cfg_word;
      else if (rd_i && sel_stat) rdata_o <= stat_word;
      else rdata_o <= 32'h0000_0000;
    end
  end

  AST_BASE_IN_WINDOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ULPC_HS_BASE_BITS >= ULPC_HS_MIN_BITS) && (ULPC_HS_BASE_BITS <= ULPC_HS_MAX_BITS))
    else $error("base hs timeout outside window");
  AST_HS_CAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 hs_timeout_bits_o == ULPC_HS_BASE_BITS + 10'($past(hs_cal_q)) * 10'd8)
    else $error("hs timeout not base plus 8 per count");
  AST_U2_SELF: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 u2_self_entry_ok_o == ($past(u2_self_q) && $past(host_u2_enable_i)))
    else $error("u2 self entry gating wrong");
  AST_U2_HOST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (u2_host_q && host_u2_request_i) |=> u2_host_accept_o)
    else $error("host u2 request not accepted");
  AST_U2_INDEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!u2_self_q && u2_host_q && host_u2_request_i) |=> u2_host_accept_o)
    else $error("self bit gates host accept");
  AST_SHIELD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (link_rst && soft_reset_shield_i) |=> $stable(u2_self_q) && $stable(u2_host_q))
    else $error("shielded u2 bits changed on link reset");
  AST_U1_RELOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (link_rst && !image_valid_i) |=> u1_wait_q == 8'h00)
    else $error("u1 wait not cleared without image");
  AST_LMP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    u2_lmp_valid_i |=> u2_idle_timeout_from_port_q == $past(u2_lmp_timeout_i))
    else $error("u2 lmp timeout not captured");
  AST_U1_RESTART: assert property (@(posedge clk_i) disable iff (!rstn_i)
    u1_rise |=> st_q == ULPC_WAIT && us_cnt_q == 8'h00)
    else $error("u1 enable did not restart wait");
  AST_U1_EARLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (u1_rise && u1_wait_q != 8'h00 && !link_rst && !cfg_wr) |=> !u1_entry_request_o [*2])
    else $error("u1 request before wait elapsed");
endmodule // ulpc_top

//--- verif/tb_top.sv
/* tb_top: register, u1 wait, u2 enable and link reset tests of ulpc_top.
   assumes: port model drives the link side; tick shortened to 2 cycles. */
`timescale 1ns/10ps
module tb_top;
  import ulpc_pkg::*;
  logic clk_i = 1'b0, rstn_i, wr_i, rd_i;
  logic usb_rst, lite_rst, shield, img_v;
  logic [7:0] img, lmp_to;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic u1e, u2e, lmp_v, idle, u2r, u1_req, self_ok, host_acc;
  logic [9:0] hs;
  int mismatches = 0, n_checks = 0, n;
  always #25 clk_i = ~clk_i;
  ulpc_port_model i_port (.clk_i(clk_i), .host_u1_enable_o(u1e), .host_u2_enable_o(u2e),
    .u2_lmp_valid_o(lmp_v), .u2_lmp_timeout_o(lmp_to), .link_idle_o(idle),
    .host_u2_request_o(u2r));
  ulpc_top #(.TICK_CYC(2)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .usb_reset_i(usb_rst),
    .lite_reset_i(lite_rst), .soft_reset_shield_i(shield), .image_valid_i(img_v),
    .image_u1_idle_wait_us_i(img), .host_u1_enable_i(u1e), .host_u2_enable_i(u2e),
    .u2_lmp_valid_i(lmp_v), .u2_lmp_timeout_i(lmp_to), .link_idle_i(idle),
    .host_u2_request_i(u2r), .u1_entry_request_o(u1_req), .u2_self_entry_ok_o(self_ok),
    .u2_host_accept_o(host_acc), .hs_timeout_bits_o(hs));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic pulse(input logic lite);
    @(posedge clk_i);
    if (lite) lite_rst <= 1'b1; else usb_rst <= 1'b1;
    @(posedge clk_i);
    {usb_rst, lite_rst} <= 2'b00;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100_000;
    mismatches++;
    close_out;
  end
  initial begin
    {rstn_i, wr_i, rd_i, usb_rst, lite_rst, shield, img_v} <= 7'h00;
    img <= 8'h00;
    addr_i <= 12'h000;
    wdata_i <= 32'h0000_0000;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ULPC_CFG_OFF); chk("cfg_rst", d, 32'h0000_0000);
    chk("hs_base", 32'(hs), 32'd768);
    rd(12'h100); chk("unmapped", d, 32'h0000_0000);
    $display("test reset done");
    wr(ULPC_CFG_OFF, 32'h03FF_F800);
    rd(ULPC_CFG_OFF); chk("cfg_wr", d, 32'h0300_F800);
    chk("hs_cal7", 32'(hs), 32'd824);
    i_port.lmp(8'h5A);
    rd(ULPC_CFG_OFF); chk("u2_to", d, 32'h035A_F800);
    $display("test config done");
    i_port.set(4'b0101);
    repeat (2) @(posedge clk_i);
    #1 chk("u2", {self_ok, host_acc}, 2'b11);
    rd(ULPC_STAT_OFF); chk("stat", d, 32'h0000_0003);
    wr(ULPC_CFG_OFF, 32'h0300_E800);
    @(posedge clk_i);
    #1 chk("u2_self0", {self_ok, host_acc}, 2'b01);
    wr(ULPC_CFG_OFF, 32'h0300_F000);
    @(posedge clk_i);
    #1 chk("u2_host0", {self_ok, host_acc}, 2'b10);
    i_port.set(4'b0001);
    repeat (2) @(posedge clk_i);
    #1 chk("u2_nohost", self_ok, 1'b0);
    {shield, img_v, img} <= {2'b11, 8'h02};
    pulse(1'b0);
    rd(ULPC_CFG_OFF); chk("shield", {d[31:24], d[12:11]}, {8'h02, 2'b10});
    {shield, img_v} <= 2'b00;
    pulse(1'b1);
    rd(ULPC_CFG_OFF); chk("noimg", d[31:24], 8'h00);
    $display("test u2 and resets done");
    wr(ULPC_CFG_OFF, 32'h0400_0000);
    i_port.set(4'b1010);
    for (n = 0; n < 40 && u1_req !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("u1_wait", 32'(n >= 8 && n <= 13), 1);
    @(posedge clk_i);
    #1 chk("u1_once", u1_req, 1'b0);
    i_port.set(4'b0010);
    i_port.set(4'b1010);
    repeat (4) @(posedge clk_i);
    i_port.set(4'b1000);
    for (n = 0; n < 20 && u1_req !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("u1_abort", n, 20);
    $display("test u1 wait done");
    close_out;
  end
endmodule // tb_top

//--- verif/ulpc_port_model.sv
/* ulpc_port_model: upstream port levels and u2_idle_timeout_from_port lmp pulses.
   assumes: called from the bench, changes lines right after clk_i rises. */
`timescale 1ns/10ps
module ulpc_port_model (
  input wire logic clk_i,
  output logic host_u1_enable_o,
  output logic host_u2_enable_o,
  output logic u2_lmp_valid_o,
  output logic [7:0] u2_lmp_timeout_o,
  output logic link_idle_o,
  output logic host_u2_request_o
);
  initial begin
    {host_u1_enable_o, host_u2_enable_o, link_idle_o, host_u2_request_o} = 4'h0;
    u2_lmp_valid_o = 1'b0;
    u2_lmp_timeout_o = 8'h00;
  end
  task automatic set(input logic [3:0] lv);
    @(posedge clk_i);
    {host_u1_enable_o, host_u2_enable_o, link_idle_o, host_u2_request_o} <= lv;
  endtask
  // timeout lines go inverted after the pulse so a stale value is never caught
  task automatic lmp(input logic [7:0] v);
    @(posedge clk_i);
    u2_lmp_valid_o <= 1'b1;
    u2_lmp_timeout_o <= v;
    @(posedge clk_i);
    u2_lmp_valid_o <= 1'b0;
    u2_lmp_timeout_o <= ~v;
  endtask
endmodule // ulpc_port_model
